// File: psef_pkg.sv
package psef_pkg;

   // Message header and layout.
   localparam logic [7:0] PSEF_MSG_LEN      = 8'h11;
   localparam logic [7:0] PSEF_EVT_CODE     = 8'h88;
   localparam int         PSEF_MAP_BITS     = 64;
   localparam int         PSEF_MAP_BYTES    = 8;
   localparam logic [4:0] PSEF_LAST_IDX     = 5'h11;
   localparam logic [4:0] PSEF_OPEN_FIRST   = 5'h02;
   localparam logic [4:0] PSEF_PEND_FIRST   = 5'h0A;
   localparam int         PSEF_DISC_BIT     = 0;
   localparam int         PSEF_UNUSED_BIT   = 63;

   // Mask of the bits that carry real pipes (1..62).
   localparam logic [63:0] PSEF_PIPE_MASK   = 64'h7FFF_FFFF_FFFF_FFFE;

   // APB register byte addresses.
   localparam logic [7:0] PSEF_A_CTRL       = 8'h00;
   localparam logic [7:0] PSEF_A_OPEN_LO    = 8'h04;
   localparam logic [7:0] PSEF_A_OPEN_HI    = 8'h08;
   localparam logic [7:0] PSEF_A_PEND_LO    = 8'h0C;
   localparam logic [7:0] PSEF_A_PEND_HI    = 8'h10;
   localparam logic [7:0] PSEF_A_STATUS     = 8'h14;
   localparam logic [7:0] PSEF_A_INT_STAT   = 8'h18;
   localparam logic [7:0] PSEF_A_INT_EN     = 8'h1C;
   localparam logic [7:0] PSEF_A_INT_CLR    = 8'h20;
   localparam logic [7:0] PSEF_A_GRANT_LO   = 8'h24;
   localparam logic [7:0] PSEF_A_GRANT_HI   = 8'h28;

   // Control bit positions.
   localparam int         PSEF_C_DISC_DONE  = 0;
   localparam int         PSEF_C_NO_DISC    = 1;
   localparam int         PSEF_C_SEND       = 2;

   // Interrupt bit positions.
   localparam int         PSEF_I_SENT       = 0;
   localparam int         PSEF_I_CHANGE     = 1;
   localparam int         PSEF_INT_W        = 2;

   typedef enum {PSEF_IDLE, PSEF_SEND, PSEF_WAIT} psef_state_t;

endpackage

// File: psef_byte_sel.sv
`timescale 1ns/1ps
`default_nettype none

// Picks one message byte from the header and the two maps, registered.
module psef_byte_sel (
   input  wire logic                          sys_clk,
   input  wire logic                          rstn,
   input  wire logic [4:0]                    idx,
   input  wire logic [psef_pkg::PSEF_MAP_BITS-1:0] open_map,
   input  wire logic [psef_pkg::PSEF_MAP_BITS-1:0] pend_map,
   output logic      [7:0]                    byte_out
);
   import psef_pkg::*;

   typedef struct packed {
      logic [7:0] data_r;
   } psef_sel_st_t;

   psef_sel_st_t st_r;
   psef_sel_st_t st_nxt;
   logic [4:0]   off_open;
   logic [4:0]   off_pend;

   assign off_open = idx - PSEF_OPEN_FIRST;
   assign off_pend = idx - PSEF_PEND_FIRST;

   // Map byte k carries bits 8k+7..8k, least significant byte first.
   always_comb begin
      st_nxt = st_r;
      if (idx == 5'h00) begin
         st_nxt.data_r = PSEF_MSG_LEN;
      end else if (idx == 5'h01) begin
         st_nxt.data_r = PSEF_EVT_CODE;
      end else if (idx < PSEF_PEND_FIRST) begin
         st_nxt.data_r = open_map[{off_open[2:0], 3'h0} +: 8];
      end else begin
         st_nxt.data_r = pend_map[{off_pend[2:0], 3'h0} +: 8];
      end
   end

   // Read data leave from a register.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign byte_out = st_r.data_r;

endmodule

`default_nettype wire

// File: psef_framer.sv
// Summary of operation
// - Send event whenever pipe availability changes.
// - Payload holds two 64-bit pipe bitmaps.
// - Open map: one means usable now.
// - Pending map: one means open first.
// - Pipe numbering starts at first byte LSB.
// - Bits 1..62 are pipes; 63 unused.
// - Open map bit 0 reports discovery done.
// - No discovery needed reports bit 0 one.
// - Pending map bit 0 always zero.
// - Eight bytes each, open map first.
// - Pending pipes take data only once granted.
`timescale 1ns/1ps
`default_nettype none

module psef_framer (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        tx_ready,
   output logic             tx_valid,
   output logic      [7:0]  tx_data,
   output logic             tx_first,
   output logic             tx_last,
   output logic      [63:0] rx_allowed,
   output logic             irq
);
   import psef_pkg::*;

   typedef struct packed {
      logic [63:0]          open_r;
      logic [63:0]          pend_r;
      logic [63:0]          grant_r;
      logic                 disc_done_r;
      logic                 no_disc_r;
      logic [63:0]          snap_open_r;
      logic [63:0]          snap_pend_r;
      logic                 dirty_r;
      psef_state_t          state_r;
      logic [4:0]           idx_r;
      logic                 tx_valid_r;
      logic                 tx_first_r;
      logic                 tx_last_r;
      logic [31:0]          prdata_r;
      logic                 pready_r;
      logic                 pslverr_r;
      logic [PSEF_INT_W-1:0] int_stat_r;
      logic [PSEF_INT_W-1:0] int_en_r;
      logic                 irq_r;
      logic [63:0]          rx_allowed_r;
   } psef_st_t;

   psef_st_t    st_r;
   psef_st_t    st_nxt;
   logic [7:0]  sel_byte;
   logic [63:0] open_view;
   logic [63:0] pend_view;

   // True when a write access completes at this edge to the given address.
   function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] want,
                                   input logic s, input logic e, input logic w);
      wr_hit = s && e && w && (a == want);
   endfunction

   // The maps as sent: discovery status in bit 0 of the open map, pipe bits masked.
   always_comb begin
      open_view = st_r.open_r & PSEF_PIPE_MASK;
      open_view[PSEF_DISC_BIT] = st_r.disc_done_r | st_r.no_disc_r;
      pend_view = st_r.pend_r & PSEF_PIPE_MASK;
   end

   // The byte picker reads the snapshot taken at frame start, so a change mid-frame
   // cannot tear a message; the change is flagged and sent in the next frame.
   psef_byte_sel u_sel (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .idx      (st_nxt.idx_r),
      .open_map (st_nxt.snap_open_r),
      .pend_map (st_nxt.snap_pend_r),
      .byte_out (sel_byte)
   );

   // Register file, change detection, framing and interrupts.
   always_comb begin
      logic        acc;
      logic        wen;
      logic [31:0] rd;
      logic [PSEF_INT_W-1:0] ev;
      logic [PSEF_INT_W-1:0] clr;
      logic        changed;
      logic [63:0] new_open;
      logic [63:0] new_pend;
      acc      = 1'b0;
      wen      = 1'b0;
      rd       = 32'h0000_0000;
      ev       = '0;
      clr      = '0;
      changed  = 1'b0;
      new_open = 64'h0;
      new_pend = 64'h0;
      st_nxt   = st_r;
      acc      = psel && penable && !st_r.pready_r;
      // A write lands only at the edge where the master sees pready high.
      wen      = psel && penable && st_r.pready_r;

      // Writes by software.
      if (wr_hit(paddr, PSEF_A_CTRL, psel, wen, pwrite)) begin
         st_nxt.disc_done_r = pwdata[PSEF_C_DISC_DONE];
         st_nxt.no_disc_r   = pwdata[PSEF_C_NO_DISC];
         if (pwdata[PSEF_C_SEND]) begin
            st_nxt.dirty_r = 1'b1;
         end
      end
      if (wr_hit(paddr, PSEF_A_OPEN_LO, psel, wen, pwrite)) begin
         st_nxt.open_r[31:0] = pwdata;
      end
      if (wr_hit(paddr, PSEF_A_OPEN_HI, psel, wen, pwrite)) begin
         st_nxt.open_r[63:32] = pwdata;
      end
      if (wr_hit(paddr, PSEF_A_PEND_LO, psel, wen, pwrite)) begin
         st_nxt.pend_r[31:0] = pwdata;
      end
      if (wr_hit(paddr, PSEF_A_PEND_HI, psel, wen, pwrite)) begin
         st_nxt.pend_r[63:32] = pwdata;
      end
      if (wr_hit(paddr, PSEF_A_GRANT_LO, psel, wen, pwrite)) begin
         st_nxt.grant_r[31:0] = pwdata;
      end
      if (wr_hit(paddr, PSEF_A_GRANT_HI, psel, wen, pwrite)) begin
         st_nxt.grant_r[63:32] = pwdata;
      end
      if (wr_hit(paddr, PSEF_A_INT_EN, psel, wen, pwrite)) begin
         st_nxt.int_en_r = pwdata[PSEF_INT_W-1:0];
      end
      if (wr_hit(paddr, PSEF_A_INT_CLR, psel, wen, pwrite)) begin
         clr = pwdata[PSEF_INT_W-1:0];
      end

      // Any change of the transmitted maps arms a new message.
      new_open = st_nxt.open_r & PSEF_PIPE_MASK;
      new_open[PSEF_DISC_BIT] = st_nxt.disc_done_r | st_nxt.no_disc_r;
      new_pend = st_nxt.pend_r & PSEF_PIPE_MASK;
      changed  = (new_open != open_view) || (new_pend != pend_view);
      if (changed) begin
         st_nxt.dirty_r = 1'b1;
         ev[PSEF_I_CHANGE] = 1'b1;
      end

      // Receive gate: open pipes, or pending pipes once set in the grant register.
      st_nxt.rx_allowed_r = (new_open | (new_pend & st_nxt.grant_r)) & PSEF_PIPE_MASK;

      // Frame sequencer, one byte per accepted handshake.
      case (st_r.state_r)
         PSEF_IDLE: begin
            if (st_r.dirty_r) begin
               st_nxt.dirty_r     = changed;
               st_nxt.snap_open_r = open_view;
               st_nxt.snap_pend_r = pend_view;
               st_nxt.idx_r       = 5'h00;
               st_nxt.state_r     = PSEF_SEND;
            end
         end
         PSEF_SEND: begin
            // Byte selector is fed st_nxt.idx_r, so its result is valid in the same cycle that idx_r settles.
            st_nxt.tx_valid_r = 1'b1;
            st_nxt.tx_first_r = (st_r.idx_r == 5'h00);
            st_nxt.tx_last_r  = (st_r.idx_r == PSEF_LAST_IDX);
            st_nxt.state_r    = PSEF_WAIT;
         end
         PSEF_WAIT: begin
            if (tx_ready) begin
               st_nxt.tx_valid_r = 1'b0;
               st_nxt.tx_first_r = 1'b0;
               st_nxt.tx_last_r  = 1'b0;
               if (st_r.tx_last_r) begin
                  ev[PSEF_I_SENT] = 1'b1;
                  st_nxt.state_r  = PSEF_IDLE;
               end else begin
                  st_nxt.idx_r   = st_r.idx_r + 5'h01;
                  st_nxt.state_r = PSEF_SEND;
               end
            end
         end
         default: begin
            st_nxt.state_r = PSEF_IDLE;
         end
      endcase

      // Sticky status; a new event wins over a clear in the same cycle.
      st_nxt.int_stat_r = (st_r.int_stat_r & ~clr) | ev;
      st_nxt.irq_r      = |(st_nxt.int_stat_r & st_nxt.int_en_r);

      // Read mux and APB answer: one wait state, then pready for one cycle.
      case (paddr)
         PSEF_A_CTRL:     rd = {29'h0, 1'b0, st_r.no_disc_r, st_r.disc_done_r};
         PSEF_A_OPEN_LO:  rd = st_r.open_r[31:0];
         PSEF_A_OPEN_HI:  rd = st_r.open_r[63:32];
         PSEF_A_PEND_LO:  rd = st_r.pend_r[31:0];
         PSEF_A_PEND_HI:  rd = st_r.pend_r[63:32];
         PSEF_A_STATUS:   rd = {30'h0, st_r.dirty_r, (st_r.state_r != PSEF_IDLE)};
         PSEF_A_INT_STAT: rd = {30'h0, st_r.int_stat_r};
         PSEF_A_INT_EN:   rd = {30'h0, st_r.int_en_r};
         PSEF_A_INT_CLR:  rd = 32'h0000_0000;
         PSEF_A_GRANT_LO: rd = st_r.grant_r[31:0];
         PSEF_A_GRANT_HI: rd = st_r.grant_r[63:32];
         default:         rd = 32'h0000_0000;
      endcase
      st_nxt.pready_r  = acc;
      st_nxt.pslverr_r = acc && (paddr > PSEF_A_GRANT_HI || paddr[1:0] != 2'h0);
      st_nxt.prdata_r  = (acc && !pwrite) ? rd : 32'h0000_0000;
   end

   // All state in one register.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         st_r         <= '0;
         st_r.state_r <= PSEF_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata     = st_r.prdata_r;
   assign pready     = st_r.pready_r;
   assign pslverr    = st_r.pslverr_r;
   assign tx_valid   = st_r.tx_valid_r;
   assign tx_data    = sel_byte;
   assign tx_first   = st_r.tx_first_r;
   assign tx_last    = st_r.tx_last_r;
   assign rx_allowed = st_r.rx_allowed_r;
   assign irq        = st_r.irq_r;

endmodule

`default_nettype wire

// File: psef_chk.sv
`timescale 1ns/1ps
`default_nettype none
module psef_chk (
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic        tx_ready,
   input wire logic        tx_valid,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_first,
   input wire logic        tx_last,
   input wire logic [63:0] rx_allowed
);
   import psef_pkg::*;
   logic [4:0] cnt_r;
   wire        take = tx_valid && tx_ready;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // Counts accepted bytes, so that every byte is tied to its slot in the frame.
   always_ff @(posedge sys_clk) begin
      if (!rstn || (take && tx_last)) cnt_r <= 5'h00;
      else if (take) cnt_r <= cnt_r + 5'h01;
   end
   property p_len; tx_valid && cnt_r == 5'h00 |-> tx_first && tx_data == PSEF_MSG_LEN; endproperty
   a_len: assert property (p_len) else $error("length byte wrong");
   property p_code; tx_valid && cnt_r == 5'h01 |-> tx_data == PSEF_EVT_CODE; endproperty
   a_code: assert property (p_code) else $error("event code byte wrong");
   property p_last; tx_valid |-> tx_last == (cnt_r == 5'h11); endproperty
   a_last: assert property (p_last) else $error("frame length wrong");
   property p_pend0; tx_valid && cnt_r == 5'h0A |-> !tx_data[0]; endproperty
   a_pend0: assert property (p_pend0) else $error("pending bit zero set");
   property p_top; tx_valid && (cnt_r == 5'h09 || cnt_r == 5'h11) |-> !tx_data[7]; endproperty
   a_top: assert property (p_top) else $error("unused bit set");
   property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
   a_hold: assert property (p_hold) else $error("byte dropped before taken");
   property p_gap; take && !tx_last |=> !tx_valid ##1 tx_valid; endproperty
   a_gap: assert property (p_gap) else $error("next byte late");
   property p_rx; rx_allowed[0] == 1'b0 && rx_allowed[63] == 1'b0; endproperty
   a_rx: assert property (p_rx) else $error("reserved receive bit set");
endmodule
bind psef_framer psef_chk psef_chk_inst (.*);
`default_nettype wire

// File: psef_sink.sv
`timescale 1ns/1ps
`default_nettype none
module psef_sink (
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic       slow,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_first,
   input  wire logic       tx_last,
   output logic            tx_ready
);
   logic [7:0] msg [0:17];
   logic [4:0] idx;
   logic       ph;
   int         frames;
   // Slow mode stalls every other cycle; with bytes two cycles apart, only the first byte of a frame can be held.
   always_ff @(posedge sys_clk) begin
      ph <= !ph && rstn;
      tx_ready <= rstn && !(slow && ph);
      if (!rstn) begin
         idx <= 5'h00;
         frames <= 0;
      end else if (tx_valid && tx_ready) begin
         msg[tx_first ? 5'h00 : idx] <= tx_data;
         idx <= tx_last ? 5'h00 : (tx_first ? 5'h01 : idx + 5'h01);
         if (tx_last) frames <= frames + 1;
      end
   end
endmodule
`default_nettype wire

// File: test_pipe_status_event_framer.sv
`timescale 1ns/1ps
`default_nettype none
module test_pipe_status_event_framer;
   import psef_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel, penable, pwrite, slow, pready, pslverr, err;
   logic        tx_ready, tx_valid, tx_first, tx_last, irq;
   logic [7:0]  paddr, tx_data;
   logic [31:0] pwdata, prdata, rd;
   logic [63:0] rx_allowed, om, pm;
   int          error_cnt = 0;
   int          checked = 0;
   int          fr;
   always #5 sys_clk = ~sys_clk;
   psef_framer psef_framer_inst (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_first(tx_first), .tx_last(tx_last), .rx_allowed(rx_allowed), .irq(irq));
   psef_sink psef_sink_inst (.sys_clk(sys_clk), .rstn(rstn), .slow(slow), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last), .tx_ready(tx_ready));
   task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One APB transfer; the request stands until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         error_cnt++;
         results;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Polls status until no message is sending or waiting.
   task automatic idle;
      int n;
      n = 0;
      repeat (4) @(posedge sys_clk);
      do begin
         apb(1'b0, PSEF_A_STATUS, 32'h0);
         n++;
      end while (rd[1:0] !== 2'b00 && n < 300);
      if (n == 300) begin
         error_cnt++;
         results;
      end
   endtask
   // Compares the last frame the sink took with the one built from the maps.
   task automatic frame(input logic [63:0] o, input logic [63:0] p);
      logic [7:0] e;
      for (int k = 0; k < 18; k++) begin
         e = k == 0 ? PSEF_MSG_LEN : k == 1 ? PSEF_EVT_CODE :
             k < 10 ? o[8*(k-2) +: 8] : p[8*(k-10) +: 8];
         chk("frame byte", psef_sink_inst.msg[k], e);
      end
   endtask
   // Main sequence; reserved map bits are written as ones so masking shows.
   initial begin
      {psel, penable, pwrite, slow} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      chk("frames after reset", psef_sink_inst.frames, 64'h0);
      apb(1'b1, PSEF_A_OPEN_LO, 32'h000D_FFFF);
      apb(1'b1, PSEF_A_OPEN_HI, 32'h8008_0000);
      apb(1'b1, PSEF_A_PEND_LO, 32'h1182_0001);
      apb(1'b1, PSEF_A_PEND_HI, 32'h8000_1000);
      idle;
      om = 64'h0008_0000_000D_FFFE;
      pm = 64'h0000_1000_1182_0000;
      frame(om, pm);
      chk("irq masked", irq, 64'h0);
      apb(1'b0, PSEF_A_INT_STAT, 32'h0);
      chk("sent flag", rd[0], 64'h1);
      apb(1'b1, PSEF_A_INT_EN, 32'h1);
      repeat (2) @(posedge sys_clk);
      chk("irq raised", irq, 64'h1);
      apb(1'b1, PSEF_A_INT_CLR, 32'h3);
      repeat (2) @(posedge sys_clk);
      chk("irq cleared", irq, 64'h0);
      chk("receive before grant", rx_allowed, om);
      apb(1'b1, PSEF_A_GRANT_LO, 32'h0002_0000);
      apb(1'b1, PSEF_A_GRANT_HI, 32'h0000_1000);
      repeat (2) @(posedge sys_clk);
      chk("receive after grant", rx_allowed, om | 64'h0000_1000_0002_0000);
      fr = psef_sink_inst.frames;
      slow <= 1'b1;
      apb(1'b1, PSEF_A_CTRL, 32'h2);
      idle;
      chk("frame on change", psef_sink_inst.frames > fr, 64'h1);
      frame(om | 64'h1, pm);
      fr = psef_sink_inst.frames;
      apb(1'b1, PSEF_A_CTRL, 32'h3);
      idle;
      chk("no frame unchanged", psef_sink_inst.frames, fr);
      apb(1'b1, PSEF_A_CTRL, 32'h0);
      idle;
      frame(om, pm);
      apb(1'b1, PSEF_A_CTRL, 32'h1);
      idle;
      frame(om | 64'h1, pm);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped error", err, 64'h1);
      chk("unmapped data", rd, 64'h0);
      results;
   end
endmodule
`default_nettype wire
